// ---- baud_gen_defs.vh ----
// Purpose: Constants for the fractional baud generator
// Assumes: Included by the generator and its divider core
// Notes: Register select codes are local to the register port
`ifndef BAUD_GEN_DEFS_VH
`define BAUD_GEN_DEFS_VH

// Register select codes on the byte register port
`define SEL_DIV_LOW 2'h0
`define SEL_DIV_HIGH 2'h1
`define SEL_DIV_FRAC 2'h2
`define SEL_MODEM_CTRL 2'h3

// Reset values, divisor of one
`define DIV_LOW_RST 8'h01
`define DIV_HIGH_RST 8'h00
`define DIV_FRAC_RST 4'h0
`define MODEM_CTRL_RST 8'h00

// Field positions and widths
`define MCR_PRESC_BIT 7
`define FRAC_W 4
`define INT_W 16
`define HIGH_SHIFT 8

// Prescaler and sample counts
`define PRESC_LAST 2'h3
`define SPB_16X_LAST 4'hF
`define SPB_8X_LAST 4'h7

`endif

// ---- frac_divider.v ----
// Purpose: Fractional divider core, integer plus sixteenths
// Assumes: tick_in is a one-cycle enable from the prescaler
// Notes: New divisor is taken only at a period boundary
`timescale 1ns/10ps
`include "baud_gen_defs.vh"

module frac_divider #(
  parameter INT_W = `INT_W,
  parameter FRAC_W = `FRAC_W
) (
  input wire clk,
  input wire arst_n,
  input wire tick_in,
  input wire [INT_W-1:0] div_int,
  input wire [FRAC_W-1:0] div_frac,
  output reg tick_out,
  output reg reload
);

  reg [INT_W:0] count_reg;
  reg [INT_W:0] count_next;
  reg [FRAC_W-1:0] acc_reg;
  reg [FRAC_W-1:0] acc_next;
  reg tick_next;
  reg carry;
  reg [FRAC_W-1:0] acc_sum;

  // Integer part of zero behaves as one
  function [INT_W:0] eff_int;
    input [INT_W-1:0] value;
    begin
      if (value == {INT_W{1'b0}}) begin
        eff_int = {{INT_W{1'b0}}, 1'b1};
      end else begin
        eff_int = {1'b0, value};
      end
    end
  endfunction

  // Count prescaled ticks, stretch a period when accumulator carries
  always @* begin
    {carry, acc_sum} = {1'b0, acc_reg} + {1'b0, div_frac};
    count_next = count_reg;
    acc_next = acc_reg;
    tick_next = 1'b0;
    if (tick_in) begin
      if (count_reg <= {{INT_W{1'b0}}, 1'b1}) begin
        tick_next = 1'b1;
        acc_next = acc_sum;
        count_next = eff_int(div_int) + {{INT_W{1'b0}}, carry};
      end else begin
        count_next = count_reg - {{INT_W{1'b0}}, 1'b1};
      end
    end
  end

  // State flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= {{INT_W{1'b0}}, 1'b1};
      acc_reg <= {FRAC_W{1'b0}};
      tick_out <= 1'b0;
      reload <= 1'b0;
    end else begin
      count_reg <= count_next;
      acc_reg <= acc_next;
      tick_out <= tick_next;
      reload <= tick_next;
    end
  end

endmodule // frac_divider

// ---- baud_generator.v ----
// Purpose: Per-channel fractional baud generator with prescaler
// Assumes: CLK is the oscillator input clock, inputs synchronous
// Notes: Sample tick is 16X or 8X of the serial bit rate
`timescale 1ns/10ps
`include "baud_gen_defs.vh"

module baud_generator #(
  parameter INT_W = `INT_W,
  parameter FRAC_W = `FRAC_W
) (
  input wire CLK,
  input wire ARST_N,
  input wire SOFT_RST,
  input wire REG_WR,
  input wire [1:0] REG_SEL,
  input wire [7:0] REG_WDATA,
  input wire SAMPLE_8X,
  output reg [7:0] REG_RDATA,
  output wire [7:0] MODEM_CTRL,
  output wire SAMPLE_TICK,
  output reg BIT_TICK,
  output reg DIV_PENDING
);

  // Divisor and control registers
  reg [7:0] div_low_reg;
  reg [7:0] div_low_next;
  reg [7:0] div_high_reg;
  reg [7:0] div_high_next;
  reg [FRAC_W-1:0] div_frac_reg;
  reg [FRAC_W-1:0] div_frac_next;
  reg [7:0] mcr_reg;
  reg [7:0] mcr_next;

  // Prescaler state
  reg [1:0] presc_reg;
  reg [1:0] presc_next;
  reg presc_mode_reg;
  wire presc_div4;
  wire presc_tick;

  // Bit timing state
  reg [3:0] samp_reg;
  reg [3:0] samp_next;
  reg mode_8x_reg;
  reg bit_tick_next;
  wire [3:0] samp_last;

  // Divider link
  wire [INT_W-1:0] div_int;
  wire div_reload;
  reg [7:0] rdata_next;
  reg pending_next;
  wire div_write;
  reg wrote_reg;

  // Write decode for one register select
  function wr_hit;
    input wr;
    input [1:0] sel;
    input [1:0] code;
    begin
      wr_hit = wr && (sel == code);
    end
  endfunction

  assign div_int = {div_high_reg, div_low_reg};
  assign MODEM_CTRL = mcr_reg;
  assign presc_div4 = mcr_reg[`MCR_PRESC_BIT];
  assign div_write = wr_hit(REG_WR, REG_SEL, `SEL_DIV_LOW) ||
                     wr_hit(REG_WR, REG_SEL, `SEL_DIV_HIGH) ||
                     wr_hit(REG_WR, REG_SEL, `SEL_DIV_FRAC);

  // Divisor low byte next value
  always @* begin
    div_low_next = div_low_reg;
    if (SOFT_RST) begin
      div_low_next = `DIV_LOW_RST;
    end else if (wr_hit(REG_WR, REG_SEL, `SEL_DIV_LOW)) begin
      div_low_next = REG_WDATA;
    end
  end

  // Divisor high byte next value
  always @* begin
    div_high_next = div_high_reg;
    if (SOFT_RST) begin
      div_high_next = `DIV_HIGH_RST;
    end else if (wr_hit(REG_WR, REG_SEL, `SEL_DIV_HIGH)) begin
      div_high_next = REG_WDATA;
    end
  end

  // Fraction keeps only its low four bits
  always @* begin
    div_frac_next = div_frac_reg;
    if (SOFT_RST) begin
      div_frac_next = `DIV_FRAC_RST;
    end else if (wr_hit(REG_WR, REG_SEL, `SEL_DIV_FRAC)) begin
      div_frac_next = REG_WDATA[FRAC_W-1:0];
    end
  end

  // Modem control, bit 7 drives the prescaler
  always @* begin
    mcr_next = mcr_reg;
    if (SOFT_RST) begin
      mcr_next = `MODEM_CTRL_RST;
    end else if (wr_hit(REG_WR, REG_SEL, `SEL_MODEM_CTRL)) begin
      mcr_next = REG_WDATA;
    end
  end

  // Divisor low byte flop, hardware reset to one
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_low_reg <= `DIV_LOW_RST;
    end else begin
      div_low_reg <= div_low_next;
    end
  end

  // Divisor high byte flop
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_high_reg <= `DIV_HIGH_RST;
    end else begin
      div_high_reg <= div_high_next;
    end
  end

  // Divisor fraction flop
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_frac_reg <= `DIV_FRAC_RST;
    end else begin
      div_frac_reg <= div_frac_next;
    end
  end

  // Modem control flop, prescaler off after reset
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mcr_reg <= `MODEM_CTRL_RST;
    end else begin
      mcr_reg <= mcr_next;
    end
  end

  // Read mux, unused fraction bits read zero
  always @* begin
    case (REG_SEL)
      `SEL_DIV_LOW: begin
        rdata_next = div_low_reg;
      end
      `SEL_DIV_HIGH: begin
        rdata_next = div_high_reg;
      end
      `SEL_DIV_FRAC: begin
        rdata_next = {{(8-FRAC_W){1'b0}}, div_frac_reg};
      end
      `SEL_MODEM_CTRL: begin
        rdata_next = mcr_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data flop, one cycle behind the select
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_next;
    end
  end

  // Prescaler tick: every clock, or every fourth
  assign presc_tick = presc_div4 ? (presc_reg == `PRESC_LAST) : 1'b1;

  // Prescaler counter restarts when the mode changes
  always @* begin
    presc_next = presc_reg + 2'h1;
    if (presc_div4 != presc_mode_reg) begin
      presc_next = 2'h0;
    end else if (!presc_div4) begin
      presc_next = 2'h0;
    end
  end

  // Prescaler count on the oscillator clock
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_reg <= 2'h0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // Last prescaler mode, to spot a change of bit 7
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_mode_reg <= 1'b0;
    end else begin
      presc_mode_reg <= presc_div4;
    end
  end

  // Fractional divider for this channel alone
  frac_divider #(
    .INT_W(INT_W),
    .FRAC_W(FRAC_W)
  ) u_div (
    .clk(CLK),
    .arst_n(ARST_N),
    .tick_in(presc_tick),
    .div_int(div_int),
    .div_frac(div_frac_reg),
    .tick_out(SAMPLE_TICK),
    .reload(div_reload)
  );

  // Pending until reload; a reload at the change edge used the old divisor
  always @* begin
    pending_next = DIV_PENDING;
    if (div_write || SOFT_RST) begin
      pending_next = 1'b1;
    end else if (div_reload && !wrote_reg) begin
      pending_next = 1'b0;
    end
  end

  // Pending flag flop
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DIV_PENDING <= 1'b0;
    end else begin
      DIV_PENDING <= pending_next;
    end
  end

  // Divisor change seen at the last edge
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wrote_reg <= 1'b0;
    end else begin
      wrote_reg <= div_write || SOFT_RST;
    end
  end

  // Samples per bit: 16 or 8
  assign samp_last = SAMPLE_8X ? `SPB_8X_LAST : `SPB_16X_LAST;

  // Bit counter over sample ticks, restarts on mode change
  always @* begin
    samp_next = samp_reg;
    bit_tick_next = 1'b0;
    if (SAMPLE_8X != mode_8x_reg) begin
      samp_next = 4'h0;
    end else if (SAMPLE_TICK) begin
      if (samp_reg >= samp_last) begin
        samp_next = 4'h0;
        bit_tick_next = 1'b1;
      end else begin
        samp_next = samp_reg + 4'h1;
      end
    end
  end

  // Bit counter flops; the stretch pattern spans two 8X bits
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      samp_reg <= 4'h0;
      mode_8x_reg <= 1'b0;
    end else begin
      samp_reg <= samp_next;
      mode_8x_reg <= SAMPLE_8X;
    end
  end

  // Bit tick pulse flop
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BIT_TICK <= 1'b0;
    end else begin
      BIT_TICK <= bit_tick_next;
    end
  end

endmodule // baud_generator

// ---- baud_checker.sv ----
// Purpose: Port checker for the baud generator
// Assumes: Sees only the top ports
// Notes: Bound after the module
`timescale 1ns/10ps
module baud_checker (
  input wire CLK,
  input wire ARST_N,
  input wire SOFT_RST,
  input wire REG_WR,
  input wire [1:0] REG_SEL,
  input wire [7:0] REG_WDATA,
  input wire SAMPLE_8X,
  input wire [7:0] REG_RDATA,
  input wire [7:0] MODEM_CTRL,
  input wire SAMPLE_TICK,
  input wire BIT_TICK,
  input wire DIV_PENDING
);
  // One clock domain
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Tick order and spacing
  chk_bit_after: assert property (BIT_TICK |-> $past(SAMPLE_TICK))
    else $error("lone bit tick");
  chk_bit_gap: assert property (BIT_TICK |=> !BIT_TICK [*7])
    else $error("bit ticks too close");
  chk_presc_gap: assert property (
    SAMPLE_TICK && MODEM_CTRL[7] && $past(MODEM_CTRL[7], 3)
    |=> !SAMPLE_TICK [*3]) else $error("prescale ignored");
  chk_first_tick: assert property (
    $rose(ARST_N) |-> ##[0:3] SAMPLE_TICK) else $error("no early tick");
  // Register port
  chk_ctrl_write: assert property (
    REG_WR && REG_SEL == 2'h3 && !SOFT_RST
    |=> MODEM_CTRL == $past(REG_WDATA)) else $error("control lost");
  chk_soft_clear: assert property (
    SOFT_RST |=> MODEM_CTRL == 8'h00) else $error("soft reset failed");
  chk_frac_upper: assert property (
    $past(REG_SEL) == 2'h2 |-> REG_RDATA[7:4] == 4'h0)
    else $error("fraction upper set");
  chk_pend_set: assert property (
    REG_WR && REG_SEL != 2'h3 && !SOFT_RST |=> DIV_PENDING)
    else $error("no pending flag");
  // Main scenarios reached
  cov_8x: cover property (BIT_TICK && SAMPLE_8X);
  cov_presc: cover property (SAMPLE_TICK && MODEM_CTRL[7]);
  cov_reload: cover property ($fell(DIV_PENDING));
endmodule // baud_checker

bind baud_generator baud_checker baud_checker_inst (.CLK, .ARST_N,
  .SOFT_RST, .REG_WR, .REG_SEL, .REG_WDATA, .SAMPLE_8X, .REG_RDATA,
  .MODEM_CTRL, .SAMPLE_TICK, .BIT_TICK, .DIV_PENDING);

// ---- sample_consumer.sv ----
// Purpose: Stand-in for the channel datapath
// Assumes: Ticks are one-cycle pulses
// Notes: Sums 16 periods, counts samples per bit
`timescale 1ns/10ps
module sample_consumer (
  input wire clk,
  input wire arst_n,
  input wire clear,
  input wire sample_tick,
  input wire bit_tick,
  output reg [4:0] ticks,
  output reg [19:0] cycles,
  output reg [4:0] spb
);
  reg armed;
  reg [4:0] cnt;
  // Period sum from first tick
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n || clear) begin
      armed <= 1'b0;
      ticks <= 5'h00;
      cycles <= 20'h00000;
    end else if (!armed) begin
      armed <= sample_tick;
    end else if (ticks != 5'h10) begin
      cycles <= cycles + 20'h00001;
      ticks <= ticks + {4'h0, sample_tick};
    end
  end
  // Samples in each bit time
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 5'h00;
      spb <= 5'h00;
    end else if (bit_tick) begin
      cnt <= {4'h0, sample_tick};
      spb <= cnt;
    end else begin
      cnt <= cnt + {4'h0, sample_tick};
    end
  end
endmodule // sample_consumer

// ---- tb.sv ----
// Purpose: Self-checking bench for the baud generator
// Assumes: Inputs change on the falling edge
// Notes: Periods judged by the sample consumer
`timescale 1ns/10ps
module tb;
  reg CLK, ARST_N, SOFT_RST, REG_WR, SAMPLE_8X, clear;
  reg [1:0] REG_SEL;
  reg [7:0] REG_WDATA, d;
  wire [7:0] REG_RDATA, MODEM_CTRL;
  wire SAMPLE_TICK, BIT_TICK, DIV_PENDING;
  wire [4:0] ticks, spb;
  wire [19:0] cycles;
  integer err_total, comparisons, n;
  baud_generator baud_generator_inst (.CLK, .ARST_N, .SOFT_RST, .REG_WR,
    .REG_SEL, .REG_WDATA, .SAMPLE_8X, .REG_RDATA, .MODEM_CTRL,
    .SAMPLE_TICK, .BIT_TICK, .DIV_PENDING);
  sample_consumer sample_consumer_inst (.clk(CLK), .arst_n(ARST_N),
    .clear, .sample_tick(SAMPLE_TICK), .bit_tick(BIT_TICK), .ticks,
    .cycles, .spb);
  // 25 MHz clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch %0t: saw %0h want %0h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d, checks %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [1:0] s, input [7:0] v);
    begin
      @(negedge CLK);
      REG_WR = 1'b1;
      REG_SEL = s;
      REG_WDATA = v;
      @(negedge CLK);
      REG_WR = 1'b0;
    end
  endtask
  task rd(input [1:0] s);
    begin
      @(negedge CLK);
      REG_SEL = s;
      @(negedge CLK);
      d = REG_RDATA;
    end
  endtask
  // Bounded wait: 0 reload, 1 sixteen periods, 2 bit tick
  task wait_on(input [1:0] k);
    begin
      n = 0;
      @(negedge CLK);
      while (n < 20000 && (k == 2'h0 ? DIV_PENDING :
             k == 2'h1 ? ticks != 5'h10 : !BIT_TICK)) begin
        @(negedge CLK);
        n = n + 1;
      end
      if (n == 20000) begin
        err_total = err_total + 1;
        end_of_test;
      end
    end
  endtask
  task measure(input [19:0] exp);
    begin
      wait_on(2'h0);
      clear = 1'b1;
      @(negedge CLK);
      clear = 1'b0;
      wait_on(2'h1);
      check(cycles, exp);
    end
  endtask
  // Divisor bytes as software computes them
  task prog(input [7:0] h, input [7:0] l, input [7:0] f);
    begin
      wr(2'h1, h);
      wr(2'h0, l);
      wr(2'h2, f);
    end
  endtask
  task t_reset;
    begin
      rd(2'h0);
      check(d, 8'h01);
      rd(2'h1);
      check(d, 8'h00);
      rd(2'h2);
      check(d, 8'h00);
      measure(20'h00010);
    end
  endtask
  task t_div;
    begin
      wr(2'h2, 8'hF5);
      rd(2'h2);
      check(d, 8'h05);
      prog(8'h00, 8'h02, 8'h08);
      measure(20'h00028);
      prog(8'h00, 8'h01, 8'h0F);
      measure(20'h0001F);
      prog(8'h01, 8'h00, 8'h01);
      rd(2'h1);
      check(d, 8'h01);
      measure(20'h01001);
      prog(8'h00, 8'h00, 8'h00);
      measure(20'h00010);
    end
  endtask
  task t_presc;
    begin
      wr(2'h3, 8'h80);
      rd(2'h3);
      check(d, 8'h80);
      prog(8'h00, 8'h02, 8'h08);
      measure(20'h000A0);
      wr(2'h3, 8'h00);
    end
  endtask
  task t_mode;
    begin
      prog(8'h00, 8'h01, 8'h00);
      repeat (3) wait_on(2'h2);
      check(spb, 5'h10);
      SAMPLE_8X = 1'b1;
      repeat (3) wait_on(2'h2);
      check(spb, 5'h08);
      prog(8'h00, 8'h02, 8'h01);
      measure(20'h00021);
    end
  endtask
  // Soft reset wins over a write in the same cycle
  task t_soft;
    begin
      wr(2'h3, 8'h80);
      @(negedge CLK);
      SOFT_RST = 1'b1;
      REG_WR = 1'b1;
      REG_SEL = 2'h0;
      REG_WDATA = 8'h77;
      @(negedge CLK);
      SOFT_RST = 1'b0;
      REG_WR = 1'b0;
      rd(2'h0);
      check(d, 8'h01);
      check(MODEM_CTRL, 8'h00);
    end
  endtask
  // Reset for ten cycles, then the scenarios
  initial begin
    {ARST_N, SOFT_RST, REG_WR, SAMPLE_8X, clear} = 5'h00;
    REG_SEL = 2'h0;
    REG_WDATA = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(negedge CLK);
    ARST_N = 1'b1;
    t_reset;
    t_div;
    t_presc;
    t_mode;
    t_soft;
    end_of_test;
  end
endmodule // tb
